/* bench/pif_periph_model.sv */
// Peripheral side model: event set pulses and async port two buffer levels
`timescale 1ns/1ns
`default_nettype none
module pif_periph_model
(
   input  wire logic       clk,
   output logic      [7:0] flag2_set,
   output logic      [7:0] flag3_set,
   output logic            rx_full,
   output logic            tx_empty
);
   initial
   begin
      flag2_set = 8'h00;
      flag3_set = 8'h00;
      rx_full   = 1'b0;
      tx_empty  = 1'b0;
   end

   // One-cycle event pulses, launched just after an edge
   task automatic fire(input logic [7:0] m2, input logic [7:0] m3);
      @(posedge clk);
      flag2_set <= m2;
      flag3_set <= m3;
      @(posedge clk);
      flag2_set <= 8'h00;
      flag3_set <= 8'h00;
   endtask

   task automatic bufs(input logic full, input logic empty);
      @(posedge clk);
      rx_full  <= full;
      tx_empty <= empty;
   endtask
endmodule // pif_periph_model
`default_nettype wire

/* bench/pif_top_tb_top.sv */
// Self-checking bench for the peripheral flag and enable registers
`timescale 1ns/1ns
`default_nettype none
module pif_top_tb_top;
   logic        clk;
   logic        rstn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [7:0]  flag1;
   logic [7:0]  en3;
   logic [31:0] rd;
   logic        last_err;
   int          error_cnt = 0;
   int          checks = 0;
   wire logic [31:0] PRDATA;
   wire logic        PREADY;
   wire logic        PSLVERR;
   wire logic        PERIPH_IRQ;
   wire logic [7:0]  f2s;
   wire logic [7:0]  f3s;
   wire logic        rxf;
   wire logic        txe;
   wire logic        prio_o;
   wire logic        peripheral_irq_enable_o;

   pif_top DUT (.REF_CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .FLAG1_IN(flag1), .ENABLE3_IN(en3), .FLAG2_SET(f2s), .FLAG3_SET(f3s), .RX_TWO_FULL(rxf),
      .TX_TWO_EMPTY(txe), .PRIORITY_LEVELS_ENABLE(prio_o), .PERIPH_IRQ_ENABLE(peripheral_irq_enable_o),
      .PERIPH_IRQ(PERIPH_IRQ));
   pif_periph_model u_per (.clk(clk), .flag2_set(f2s), .flag3_set(f3s), .rx_full(rxf), .tx_empty(txe));

   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic finish_test;
      $display("checks=%0d error_cnt=%0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   // One APB transfer; request held until PREADY is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= {24'h000000, d};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (PREADY !== 1'b1 && n < 20)
      begin
         @(posedge clk);
         n++;
      end
      if (n == 20)
      begin
         error_cnt++;
         finish_test();
      end
      rd       = PRDATA;
      last_err = PSLVERR;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdchk(input string name, input logic [11:0] a, input logic [7:0] exp);
      apb(1'b0, a, 8'h00);
      chk(name, rd, {24'h000000, exp});
   endtask

   task automatic irqchk(input logic exp);
      repeat (2) @(posedge clk);
      chk("irq", {31'h0, PERIPH_IRQ}, {31'h0, exp});
   endtask

   initial
   begin
      rstn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      flag1 = 8'h00;
      en3 = 8'h00;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      for (int i = 0; i < 5; i++)
         rdchk("reset", 12'(i * 4), 8'h00);
      wr(pif_pkg::OFS_ENABLE1, 8'hFF);
      rdchk("enable1", pif_pkg::OFS_ENABLE1, 8'hFF);
      wr(pif_pkg::OFS_ENABLE2, 8'hFF);
      rdchk("enable2", pif_pkg::OFS_ENABLE2, 8'hDF);
      wr(pif_pkg::OFS_FLAG2, 8'hFF);
      rdchk("flag2_sw", pif_pkg::OFS_FLAG2, 8'hDF);
      wr(pif_pkg::OFS_ENABLE1, 8'h00);
      wr(pif_pkg::OFS_ENABLE2, 8'h00);
      wr(pif_pkg::OFS_FLAG2, 8'h00);
      for (int i = 0; i < 8; i++)
      begin
         u_per.fire(8'h01 << i, 8'h01 << i);
         rdchk("flag2_hw", pif_pkg::OFS_FLAG2, 8'hDF & (8'h01 << i));
         rdchk("flag3_hw", pif_pkg::OFS_FLAG3, 8'hCF & (8'h01 << i));
         irqchk(1'b0);
         wr(pif_pkg::OFS_FLAG2, 8'h00);
         wr(pif_pkg::OFS_FLAG3, 8'h00);
      end
      // Clear write and comparator event land on the same edge
      fork
         wr(pif_pkg::OFS_FLAG2, 8'h00);
         begin
            repeat (2) @(posedge clk);
            u_per.fire(8'h40, 8'h00);
         end
      join
      rdchk("set_wins", pif_pkg::OFS_FLAG2, 8'h40);
      wr(pif_pkg::OFS_FLAG2, 8'h00);
      u_per.bufs(1'b1, 1'b0);
      wr(pif_pkg::OFS_FLAG3, 8'h00);
      rdchk("rx_two", pif_pkg::OFS_FLAG3, 8'h20);
      u_per.bufs(1'b0, 1'b1);
      wr(pif_pkg::OFS_FLAG3, 8'hFF);
      rdchk("tx_two", pif_pkg::OFS_FLAG3, 8'hDF);
      wr(pif_pkg::OFS_FLAG3, 8'h00);
      u_per.bufs(1'b0, 1'b0);
      rdchk("bufs_off", pif_pkg::OFS_FLAG3, 8'h00);
      u_per.fire(8'h02, 8'h00);
      wr(pif_pkg::OFS_ENABLE2, 8'h02);
      irqchk(1'b0);
      wr(pif_pkg::OFS_CTRL, 8'h02);
      irqchk(1'b1);
      chk("peripheral_irq_enable_pin", {31'h0, peripheral_irq_enable_o}, 32'h00000001);
      chk("prio_pin", {31'h0, prio_o}, 32'h00000000);
      rdchk("ctrl", pif_pkg::OFS_CTRL, 8'h06);
      wr(pif_pkg::OFS_ENABLE2, 8'h00);
      irqchk(1'b0);
      wr(pif_pkg::OFS_ENABLE2, 8'h02);
      irqchk(1'b1);
      wr(pif_pkg::OFS_CTRL, 8'h01);
      irqchk(1'b1);
      chk("prio_pin", {31'h0, prio_o}, 32'h00000001);
      chk("peripheral_irq_enable_pin", {31'h0, peripheral_irq_enable_o}, 32'h00000000);
      wr(pif_pkg::OFS_ENABLE2, 8'h00);
      irqchk(1'b0);
      flag1 <= 8'h80;
      wr(pif_pkg::OFS_ENABLE1, 8'h80);
      irqchk(1'b1);
      wr(pif_pkg::OFS_CTRL, 8'h02);
      irqchk(1'b1);
      wr(pif_pkg::OFS_ENABLE1, 8'h00);
      u_per.fire(8'h00, 8'h08);
      en3 <= 8'h08;
      irqchk(1'b1);
      en3 <= 8'h00;
      irqchk(1'b0);
      apb(1'b1, 12'h014, 8'hFF);
      chk("unmapped_wr_err", {31'h0, last_err}, 32'h00000001);
      rdchk("ctrl_kept", pif_pkg::OFS_CTRL, 8'h02);
      apb(1'b0, 12'h014, 8'h00);
      chk("unmapped_err", {31'h0, last_err}, 32'h00000001);
      chk("unmapped_data", rd, 32'h00000000);
      finish_test();
   end
endmodule // pif_top_tb_top
`default_nettype wire

/* hdl/pif_pkg.sv */
// Register map, field positions and state types of the peripheral flag unit
package pif_pkg;

   localparam logic [11:0] OFS_FLAG2   = 12'h000;
   localparam logic [11:0] OFS_FLAG3   = 12'h004;
   localparam logic [11:0] OFS_ENABLE1 = 12'h008;
   localparam logic [11:0] OFS_ENABLE2 = 12'h00C;
   localparam logic [11:0] OFS_CTRL    = 12'h010;

   localparam int B_OSC_FAIL        = 7;
   localparam int B_COMPARATOR      = 6;
   localparam int B_UNUSED          = 5;
   localparam int B_NV_DONE         = 4;
   localparam int B_COLLISION_ONE   = 3;
   localparam int B_VOLTAGE         = 2;
   localparam int B_TIMER_THREE     = 1;
   localparam int B_CAPCOMP_TWO     = 0;

   localparam int B_SYNC_TWO        = 7;
   localparam int B_COLLISION_TWO   = 6;
   localparam int B_RX_TWO          = 5;
   localparam int B_TX_TWO          = 4;
   localparam int B_TIMER_FOUR      = 3;
   localparam int B_CAPCOMP_FIVE    = 2;
   localparam int B_CAPCOMP_FOUR    = 1;
   localparam int B_CAPCOMP_THREE   = 0;

   localparam int B_PRIO_LEVELS     = 0;
   localparam int B_PERIPH_ENABLE   = 1;
   localparam int B_REQUEST_STATE   = 2;

   localparam logic [7:0] FLAG2_MASK   = 8'hDF;
   localparam logic [7:0] FLAG3_SW_MASK = 8'hCF;
   localparam logic [7:0] RST_FLAG     = 8'h00;
   localparam logic [7:0] RST_ENABLE   = 8'h00;
   localparam logic [1:0] RST_CTRL     = 2'h0;

   typedef enum {
      REG_FLAG2,
      REG_FLAG3,
      REG_ENABLE1,
      REG_ENABLE2,
      REG_CTRL,
      REG_NONE
   } pif_reg_e;

   typedef struct packed {
      logic [7:0]  flag2;
      logic [7:0]  flag3;
      logic [7:0]  en1;
      logic [7:0]  en2;
      logic [1:0]  ctrl;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        irq;
   } pif_state_s;

endpackage

/* hdl/pif_top.sv */
// Peripheral interrupt flag and enable registers behind an APB slave
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none

module pif_top
(
   input  wire logic        REF_CLK,
   input  wire logic        RSTN,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic [7:0]  FLAG1_IN,
   input  wire logic [7:0]  ENABLE3_IN,
   input  wire logic [7:0]  FLAG2_SET,
   input  wire logic [7:0]  FLAG3_SET,
   input  wire logic        RX_TWO_FULL,
   input  wire logic        TX_TWO_EMPTY,
   output logic             PRIORITY_LEVELS_ENABLE,
   output logic             PERIPH_IRQ_ENABLE,
   output logic             PERIPH_IRQ
);

   pif_pkg::pif_state_s st;
   pif_pkg::pif_state_s next_st;
   pif_pkg::pif_reg_e   idx;
   logic                acc;
   logic                done;
   logic                wr;

   // Address to register index; misaligned or unknown gives none
   function automatic pif_pkg::pif_reg_e reg_index(input logic [11:0] a);
      pif_pkg::pif_reg_e r;
      case (a)
         pif_pkg::OFS_FLAG2:   r = pif_pkg::REG_FLAG2;
         pif_pkg::OFS_FLAG3:   r = pif_pkg::REG_FLAG3;
         pif_pkg::OFS_ENABLE1: r = pif_pkg::REG_ENABLE1;
         pif_pkg::OFS_ENABLE2: r = pif_pkg::REG_ENABLE2;
         pif_pkg::OFS_CTRL:    r = pif_pkg::REG_CTRL;
         default:              r = pif_pkg::REG_NONE;
      endcase
      return r;
   endfunction

   // Combined peripheral request from flags, enables and control
   function automatic logic req_calc(
      input logic [7:0] f1,
      input logic [7:0] e1,
      input logic [7:0] f2,
      input logic [7:0] e2,
      input logic [7:0] f3,
      input logic [7:0] e3,
      input logic [1:0] c
   );
      logic any;
      any = |(f1 & e1) | |(f2 & e2 & pif_pkg::FLAG2_MASK) | |(f3 & e3);
      return any & (c[pif_pkg::B_PRIO_LEVELS] | c[pif_pkg::B_PERIPH_ENABLE]);
   endfunction

   always_comb
   begin
      next_st = st;
      idx     = reg_index(PADDR);
      acc     = PSEL & PENABLE;
      done    = acc & st.pready;
      wr      = done & PWRITE;
      next_st.pready = acc & ~st.pready;
      if (acc & ~st.pready)
      begin
         next_st.pslverr = (idx == pif_pkg::REG_NONE);
         case (idx)
            pif_pkg::REG_FLAG2:   next_st.prdata = {24'h000000, st.flag2 & pif_pkg::FLAG2_MASK};
            pif_pkg::REG_FLAG3:   next_st.prdata = {24'h000000, st.flag3};
            pif_pkg::REG_ENABLE1: next_st.prdata = {24'h000000, st.en1};
            pif_pkg::REG_ENABLE2: next_st.prdata = {24'h000000, st.en2 & pif_pkg::FLAG2_MASK};
            pif_pkg::REG_CTRL:    next_st.prdata = {29'h00000000, st.irq, st.ctrl};
            default:              next_st.prdata = 32'h00000000;
         endcase
      end
      else if (done)
      begin
         next_st.pslverr = 1'b0;
      end
      // Software writes first, hardware sets afterwards so a set wins
      if (wr)
      begin
         case (idx)
            pif_pkg::REG_FLAG2:   next_st.flag2 = PWDATA[7:0] & pif_pkg::FLAG2_MASK;
            pif_pkg::REG_FLAG3:   next_st.flag3 = PWDATA[7:0] & pif_pkg::FLAG3_SW_MASK;
            pif_pkg::REG_ENABLE1: next_st.en1 = PWDATA[7:0];
            pif_pkg::REG_ENABLE2: next_st.en2 = PWDATA[7:0] & pif_pkg::FLAG2_MASK;
            pif_pkg::REG_CTRL:    next_st.ctrl = PWDATA[1:0];
            default:              next_st.ctrl = next_st.ctrl;
         endcase
      end
      // Events set flags whatever the enables say
      next_st.flag2 = (next_st.flag2 | FLAG2_SET) & pif_pkg::FLAG2_MASK;
      next_st.flag3 = (next_st.flag3 | FLAG3_SET) & pif_pkg::FLAG3_SW_MASK;
      next_st.flag3[pif_pkg::B_RX_TWO] = RX_TWO_FULL;
      next_st.flag3[pif_pkg::B_TX_TWO] = TX_TWO_EMPTY;
      // Request follows the new state at once
      next_st.irq = req_calc(FLAG1_IN, next_st.en1, next_st.flag2, next_st.en2,
                             next_st.flag3, ENABLE3_IN, next_st.ctrl);
   end

   always_ff @(posedge REF_CLK)
   begin
      if (!RSTN)
      begin
         st         <= '0;
         st.flag2   <= pif_pkg::RST_FLAG;
         st.flag3   <= pif_pkg::RST_FLAG;
         st.en1     <= pif_pkg::RST_ENABLE;
         st.en2     <= pif_pkg::RST_ENABLE;
         st.ctrl    <= pif_pkg::RST_CTRL;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign PRDATA                 = st.prdata;
   assign PREADY                 = st.pready;
   assign PSLVERR                = st.pslverr;
   assign PERIPH_IRQ             = st.irq;
   assign PRIORITY_LEVELS_ENABLE = st.ctrl[pif_pkg::B_PRIO_LEVELS];
   assign PERIPH_IRQ_ENABLE      = st.ctrl[pif_pkg::B_PERIPH_ENABLE];

   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RSTN);

   sequence s_flag2_write;
      wr && idx == pif_pkg::REG_FLAG2;
   endsequence

   sequence s_enable2_write;
      wr && idx == pif_pkg::REG_ENABLE2;
   endsequence

   property p_osc_set;
      FLAG2_SET[pif_pkg::B_OSC_FAIL] |=> st.flag2[pif_pkg::B_OSC_FAIL];
   endproperty
   a_osc_set: assert property (p_osc_set) else $error("osc fail flag not set");

   property p_comp_hold;
      st.flag2[pif_pkg::B_COMPARATOR] && !wr |=> st.flag2[pif_pkg::B_COMPARATOR];
   endproperty
   a_comp_hold: assert property (p_comp_hold) else $error("comparator flag lost");

   property p_bit5_zero;
      !st.flag2[pif_pkg::B_UNUSED] && !st.en2[pif_pkg::B_UNUSED];
   endproperty
   a_bit5_zero: assert property (p_bit5_zero) else $error("unused bit five set");

   property p_nv_set;
      FLAG2_SET[pif_pkg::B_NV_DONE] |=> st.flag2[pif_pkg::B_NV_DONE];
   endproperty
   a_nv_set: assert property (p_nv_set) else $error("write done flag not set");

   property p_coll1_set;
      FLAG2_SET[pif_pkg::B_COLLISION_ONE] |=> st.flag2[pif_pkg::B_COLLISION_ONE];
   endproperty
   a_coll1_set: assert property (p_coll1_set) else $error("collision one flag not set");

   property p_volt_hold;
      st.flag2[pif_pkg::B_VOLTAGE] ##1 !$past(wr) |-> st.flag2[pif_pkg::B_VOLTAGE];
   endproperty
   a_volt_hold: assert property (p_volt_hold) else $error("voltage flag lost");

   property p_timer_three_set;
      FLAG2_SET[pif_pkg::B_TIMER_THREE] |=> st.flag2[pif_pkg::B_TIMER_THREE];
   endproperty
   a_timer_three_set: assert property (p_timer_three_set) else $error("timer three flag not set");

   property p_cc2_set;
      FLAG2_SET[pif_pkg::B_CAPCOMP_TWO] |=> st.flag2[pif_pkg::B_CAPCOMP_TWO];
   endproperty
   a_cc2_set: assert property (p_cc2_set) else $error("capcomp two flag not set");

   property p_sync2_set;
      FLAG3_SET[pif_pkg::B_SYNC_TWO] |=> st.flag3[pif_pkg::B_SYNC_TWO];
   endproperty
   a_sync2_set: assert property (p_sync2_set) else $error("sync two flag not set");

   property p_coll2_set;
      FLAG3_SET[pif_pkg::B_COLLISION_TWO] |=> st.flag3[pif_pkg::B_COLLISION_TWO];
   endproperty
   a_coll2_set: assert property (p_coll2_set) else $error("collision two flag not set");

   property p_rx2_follow;
      1'b1 |=> st.flag3[pif_pkg::B_RX_TWO] == $past(RX_TWO_FULL);
   endproperty
   a_rx2_follow: assert property (p_rx2_follow) else $error("rx two flag wrong");

   property p_tx2_follow;
      1'b1 |=> st.flag3[pif_pkg::B_TX_TWO] == $past(TX_TWO_EMPTY);
   endproperty
   a_tx2_follow: assert property (p_tx2_follow) else $error("tx two flag wrong");

   property p_timer_four_set;
      FLAG3_SET[pif_pkg::B_TIMER_FOUR] |=> st.flag3[pif_pkg::B_TIMER_FOUR];
   endproperty
   a_timer_four_set: assert property (p_timer_four_set) else $error("timer four flag not set");

   property p_cc345_set;
      FLAG3_SET[2:0] != 3'h0 |=> (st.flag3[2:0] & $past(FLAG3_SET[2:0])) == $past(FLAG3_SET[2:0]);
   endproperty
   a_cc345_set: assert property (p_cc345_set) else $error("capcomp flag not set");

   property p_pe_gate;
      !st.ctrl[pif_pkg::B_PRIO_LEVELS] && !st.ctrl[pif_pkg::B_PERIPH_ENABLE] |-> !PERIPH_IRQ;
   endproperty
   a_pe_gate: assert property (p_pe_gate) else $error("request without enable");

   property p_en1_gate;
      st.ctrl[pif_pkg::B_PERIPH_ENABLE] && !wr && (FLAG1_IN & st.en1) != 8'h00 |=> PERIPH_IRQ;
   endproperty
   a_en1_gate: assert property (p_en1_gate) else $error("enable1 source not passed");

   property p_en2_write;
      s_enable2_write ##0 ((PWDATA[7:0] & st.flag2) != 8'h00) ##0 st.ctrl[pif_pkg::B_PERIPH_ENABLE]
         |=> PERIPH_IRQ;
   endproperty
   a_en2_write: assert property (p_en2_write) else $error("enable2 write gave no request");

   property p_set_wins;
      s_flag2_write ##0 FLAG2_SET[pif_pkg::B_COMPARATOR] |=> st.flag2[pif_pkg::B_COMPARATOR];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("set lost to clear");

   property p_prio_pass;
      st.ctrl[pif_pkg::B_PRIO_LEVELS] && (st.flag2 & st.en2) != 8'h00 |-> PERIPH_IRQ;
   endproperty
   a_prio_pass: assert property (p_prio_pass) else $error("priority mode blocked request");

   property p_req_match;
      PERIPH_IRQ == req_calc($past(FLAG1_IN), st.en1, st.flag2, st.en2,
                             st.flag3, $past(ENABLE3_IN), st.ctrl);
   endproperty
   a_req_match: assert property (p_req_match) else $error("request mismatch");

   property p_ready_pulse;
      PREADY |=> !PREADY;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than a cycle");

   sequence s_access_first;
      PSEL && PENABLE && !PREADY;
   endsequence

   sequence s_access_last;
      PSEL && PENABLE && PREADY;
   endsequence

   property p_ready_answer;
      s_access_first |=> PREADY;
   endproperty
   a_ready_answer: assert property (p_ready_answer) else $error("no pready after access");

   property p_err_drop;
      s_access_last |=> !PSLVERR && !PREADY;
   endproperty
   a_err_drop: assert property (p_err_drop) else $error("response held after access");

   property p_slverr_ready;
      PSLVERR |-> PREADY;
   endproperty
   a_slverr_ready: assert property (p_slverr_ready) else $error("error without pready");

   property p_unmapped_err;
      s_access_first ##0 idx == pif_pkg::REG_NONE |=> PSLVERR && PRDATA == 32'h00000000;
   endproperty
   a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped access not refused");

   property p_unmapped_nowrite;
      wr && idx == pif_pkg::REG_NONE |=> $stable(st.en1) && $stable(st.en2) && $stable(st.ctrl);
   endproperty
   a_unmapped_nowrite: assert property (p_unmapped_nowrite) else $error("unmapped write changed state");

   property p_read_bit5;
      s_access_first ##0 (idx == pif_pkg::REG_FLAG2 || idx == pif_pkg::REG_ENABLE2)
         |=> !PRDATA[pif_pkg::B_UNUSED] && PRDATA[31:8] == 24'h000000;
   endproperty
   a_read_bit5: assert property (p_read_bit5) else $error("bit five read as one");

   property p_en1_write;
      wr && idx == pif_pkg::REG_ENABLE1 |=> st.en1 == $past(PWDATA[7:0]);
   endproperty
   a_en1_write: assert property (p_en1_write) else $error("enable1 write lost");

   property p_en2_value;
      s_enable2_write |=> st.en2 == ($past(PWDATA[7:0]) & pif_pkg::FLAG2_MASK);
   endproperty
   a_en2_value: assert property (p_en2_value) else $error("enable2 write lost");

   property p_en_hold;
      !wr |=> $stable(st.en1) && $stable(st.en2);
   endproperty
   a_en_hold: assert property (p_en_hold) else $error("enable changed without write");

   property p_ctrl_write;
      wr && idx == pif_pkg::REG_CTRL |=> st.ctrl == $past(PWDATA[1:0]);
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

   property p_ctrl_hold;
      !(wr && idx == pif_pkg::REG_CTRL) |=> $stable(st.ctrl);
   endproperty
   a_ctrl_hold: assert property (p_ctrl_hold) else $error("control changed without write");

   property p_flag2_write;
      s_flag2_write |=> st.flag2 == (($past(PWDATA[7:0]) | $past(FLAG2_SET)) & pif_pkg::FLAG2_MASK);
   endproperty
   a_flag2_write: assert property (p_flag2_write) else $error("flag2 write wrong");

   property p_flag3_write;
      wr && idx == pif_pkg::REG_FLAG3 |=> (st.flag3 & pif_pkg::FLAG3_SW_MASK)
         == (($past(PWDATA[7:0]) | $past(FLAG3_SET)) & pif_pkg::FLAG3_SW_MASK);
   endproperty
   a_flag3_write: assert property (p_flag3_write) else $error("flag3 write wrong");

   property p_en2_gate;
      st.ctrl[pif_pkg::B_PERIPH_ENABLE] && !wr && (st.flag2 & st.en2) != 8'h00 |=> PERIPH_IRQ;
   endproperty
   a_en2_gate: assert property (p_en2_gate) else $error("enable2 source not passed");

   property p_en3_gate;
      st.ctrl != 2'h0 && !wr && (st.flag3 & ENABLE3_IN & pif_pkg::FLAG3_SW_MASK) != 8'h00 |=> PERIPH_IRQ;
   endproperty
   a_en3_gate: assert property (p_en3_gate) else $error("flag3 source not passed");

endmodule // pif_top

`default_nettype wire
